//--- rtl/timer1_capture_pwm.sv
// 16-bit timer: input capture, shared byte latch and phase-correct PWM
`default_nettype none
`include "timer1_cfg.svh"

module timer1_capture_pwm
	import timer1_pkg::*;
#(
	parameter int FILTER_DEPTH = `FILTER_SAMPLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic clock_enable,
	// CPU I/O register port
	input wire io_req_t io_req,
	output logic [7:0] io_rdata,
	// Pins
	input wire logic capture_input_pin,
	input wire logic ext_clock_pin,
	output logic pwm_out_a,
	output logic pwm_oe_a,
	output logic pwm_out_b,
	output logic pwm_oe_b,
	// Interrupt requests
	input wire logic global_int_enable,
	output logic irq_overflow,
	output logic irq_compare_a,
	output logic irq_compare_b,
	output logic irq_capture
);
	generate
		if (FILTER_DEPTH < 2 || FILTER_DEPTH > 8) begin : g_bad_depth
			$error("FILTER_DEPTH must lie in 2..8");
		end
	endgenerate

	ctrl_a_t ctrl_a;
	ctrl_b_t ctrl_b;
	logic [15:0] wide_counter;
	dir_t dir;
	logic [7:0] temp;
	logic [15:0] capture_register;
	logic [3:0] flags;
	logic [3:0] mask;
	logic [9:0] pre_count;
	logic ext_prev;
	logic [FILTER_DEPTH-2:0] cap_hist;
	logic cap_level;
	logic [FILTER_DEPTH-1:0] cap_window;

	logic pwm_on;
	logic undivided;
	logic tick;
	logic [15:0] top;
	logic [15:0] next_count;
	dir_t next_dir;
	logic next_level;
	logic edge_hit;
	logic overflow_evt;
	logic [7:0] rd_byte;
	logic [7:0] low_hi;
	logic low_read;
	logic high_write;
	logic wr_cnt_low;
	logic wr_a_low;
	logic wr_b_low;
	logic [15:0] cmp_a_read;
	logic [15:0] cmp_b_read;
	logic match_a;
	logic match_b;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;

	// ----------------------------------------
	// Address decode and read mux
	// ----------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		low_hi = 8'h00;
		low_read = 1'b0;
		if (io_req.addr == `ADDR_CAP_LOW) begin
			rd_byte = capture_register[7:0];
			low_hi = capture_register[15:8];
			low_read = 1'b1;
		end else if (io_req.addr == `ADDR_CMP_A_LOW) begin
			rd_byte = cmp_a_read[7:0];
			low_hi = cmp_a_read[15:8];
			low_read = 1'b1;
		end else if (io_req.addr == `ADDR_CMP_B_LOW) begin
			rd_byte = cmp_b_read[7:0];
			low_hi = cmp_b_read[15:8];
			low_read = 1'b1;
		end else if (io_req.addr == `ADDR_CNT_LOW) begin
			rd_byte = wide_counter[7:0];
			low_hi = wide_counter[15:8];
			low_read = 1'b1;
		end else if (io_req.addr == `ADDR_CAP_HIGH
				|| io_req.addr == `ADDR_CMP_A_HIGH
				|| io_req.addr == `ADDR_CMP_B_HIGH
				|| io_req.addr == `ADDR_CNT_HIGH) begin
			rd_byte = temp;
		end else if (io_req.addr == `ADDR_CTRL_A) begin
			rd_byte = ctrl_a;
		end else if (io_req.addr == `ADDR_CTRL_B) begin
			rd_byte = ctrl_b;
		end else if (io_req.addr == `ADDR_FLAGS) begin
			rd_byte = {4'h0, flags};
		end else if (io_req.addr == `ADDR_MASK) begin
			rd_byte = {4'h0, mask};
		end
	end

	always_comb begin
		high_write = 1'b0;
		wr_cnt_low = 1'b0;
		wr_a_low = 1'b0;
		wr_b_low = 1'b0;
		if (!io_req.wr) begin
			high_write = 1'b0;
		end else if (io_req.addr == `ADDR_CMP_A_HIGH
				|| io_req.addr == `ADDR_CMP_B_HIGH
				|| io_req.addr == `ADDR_CNT_HIGH) begin
			high_write = 1'b1;
		end else if (io_req.addr == `ADDR_CNT_LOW) begin
			wr_cnt_low = 1'b1;
		end else if (io_req.addr == `ADDR_CMP_A_LOW) begin
			wr_a_low = 1'b1;
		end else if (io_req.addr == `ADDR_CMP_B_LOW) begin
			wr_b_low = 1'b1;
		end
	end

	// Read data is registered: valid on the edge after the read strobe
	always_ff @(posedge clock) begin
		if (srst)
			io_rdata <= 8'h00;
		else if (clock_enable && io_req.rd)
			io_rdata <= rd_byte;
	end

	// One latch serves all 16-bit registers, so accesses must not interleave
	always_ff @(posedge clock) begin
		if (srst)
			temp <= 8'h00;
		else if (clock_enable) begin
			if (io_req.rd && low_read)
				temp <= low_hi;
			else if (high_write)
				temp <= io_req.wdata;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_a <= '0;
			ctrl_b <= '0;
			mask <= 4'h0;
		end else if (clock_enable && io_req.wr) begin
			if (io_req.addr == `ADDR_CTRL_A) begin
				ctrl_a.mode_a <= io_req.wdata[7:6];
				ctrl_a.mode_b <= io_req.wdata[5:4];
				ctrl_a.width <= io_req.wdata[1:0];
			end else if (io_req.addr == `ADDR_CTRL_B) begin
				ctrl_b.filter <= io_req.wdata[7];
				ctrl_b.edge_rise <= io_req.wdata[6];
				ctrl_b.clk_sel <= io_req.wdata[2:0];
			end else if (io_req.addr == `ADDR_MASK) begin
				mask <= io_req.wdata[3:0];
			end
		end
	end

	assign pwm_on = ctrl_a.width != `WSEL_OFF;
	assign undivided = ctrl_b.clk_sel == `CS_DIV1;

	always_comb begin
		case (ctrl_a.width)
		`WSEL_8: top = `TOP_8;
		`WSEL_9: top = `TOP_9;
		default: top = `TOP_10;
		endcase
	end

	// ----------------------------------------
	// Timer tick
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			pre_count <= 10'h000;
			ext_prev <= 1'b0;
		end else if (clock_enable) begin
			pre_count <= pre_count + 10'h001;
			ext_prev <= ext_clock_pin;
		end
	end

	always_comb begin
		case (ctrl_b.clk_sel)
		`CS_DIV1: tick = 1'b1;
		`CS_DIV8: tick = (pre_count & `PRE_MASK_8) == `PRE_MASK_8;
		`CS_DIV64: tick = (pre_count & `PRE_MASK_64) == `PRE_MASK_64;
		`CS_DIV256: tick = (pre_count & `PRE_MASK_256) == `PRE_MASK_256;
		`CS_DIV1024: tick = pre_count == `PRE_MASK_1024;
		`CS_EXT_FALL: tick = ext_prev && !ext_clock_pin;
		`CS_EXT_RISE: tick = !ext_prev && ext_clock_pin;
		default: tick = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_comb begin
		next_count = wide_counter + `ONE16;
		next_dir = DIR_UP;
		if (pwm_on) begin
			case (dir)
			DIR_UP: begin
				if (wide_counter >= top) begin
					next_dir = DIR_DOWN;
					next_count = wide_counter - `ONE16;
				end else begin
					next_dir = DIR_UP;
				end
			end
			default: begin
				if (wide_counter == `ZERO16) begin
					next_dir = DIR_UP;
				end else begin
					next_dir = DIR_DOWN;
					next_count = wide_counter - `ONE16;
				end
			end
			endcase
		end
	end

	assign overflow_evt = tick && (pwm_on ? wide_counter == `ZERO16
		: wide_counter == `ALL16);

	always_ff @(posedge clock) begin
		if (srst) begin
			wide_counter <= `ZERO16;
			dir <= DIR_UP;
		end else if (clock_enable) begin
			if (wr_cnt_low) begin
				wide_counter <= {temp, io_req.wdata};
			end else if (tick) begin
				wide_counter <= next_count;
				dir <= next_dir;
			end
			if (!pwm_on)
				dir <= DIR_UP;
		end
	end

	// ----------------------------------------
	// Compare channels
	// ----------------------------------------
	compare_channel u_cmp_a (
		.clock(clock),
		.srst(srst),
		.clock_enable(clock_enable),
		.write_en(wr_a_low),
		.write_value({temp, io_req.wdata}),
		.read_value(cmp_a_read),
		.pwm_on(pwm_on),
		.undivided(undivided),
		.step(tick),
		.rising(next_dir == DIR_UP),
		.count_next(next_count),
		.top(top),
		.mode(ctrl_a.mode_a),
		.match(match_a),
		.pin(pwm_out_a)
	);

	compare_channel u_cmp_b (
		.clock(clock),
		.srst(srst),
		.clock_enable(clock_enable),
		.write_en(wr_b_low),
		.write_value({temp, io_req.wdata}),
		.read_value(cmp_b_read),
		.pwm_on(pwm_on),
		.undivided(undivided),
		.step(tick),
		.rising(next_dir == DIR_UP),
		.count_next(next_count),
		.top(top),
		.mode(ctrl_a.mode_b),
		.match(match_b),
		.pin(pwm_out_b)
	);

	// In PWM only modes 10/11 drive the pin; modes 00/01 leave it to the port
	always_ff @(posedge clock) begin
		if (srst) begin
			pwm_oe_a <= 1'b0;
			pwm_oe_b <= 1'b0;
		end else if (clock_enable) begin
			pwm_oe_a <= pwm_on ? ctrl_a.mode_a[`MODE_ON_BIT] : ctrl_a.mode_a != 2'h0;
			pwm_oe_b <= pwm_on ? ctrl_a.mode_b[`MODE_ON_BIT] : ctrl_a.mode_b != 2'h0;
		end
	end

	// ----------------------------------------
	// Input capture
	// ----------------------------------------
	always_comb begin
		next_level = cap_level;
		if (!ctrl_b.filter)
			next_level = capture_input_pin;
		else if (&cap_window)
			next_level = 1'b1;
		else if (~|cap_window)
			next_level = 1'b0;
	end

	// Current pin plus the stored samples, newest in bit 0
	assign cap_window = {cap_hist, capture_input_pin};
	assign edge_hit = next_level != cap_level && next_level == ctrl_b.edge_rise;

	always_ff @(posedge clock) begin
		if (srst) begin
			cap_hist <= '0;
			cap_level <= 1'b0;
		end else if (clock_enable) begin
			cap_hist <= cap_window[FILTER_DEPTH-2:0];
			cap_level <= next_level;
		end
	end

	// Bus writes never reach this register
	always_ff @(posedge clock) begin
		if (srst)
			capture_register <= `ZERO16;
		else if (clock_enable && edge_hit)
			capture_register <= wide_counter;
	end

	// ----------------------------------------
	// Flags and interrupt requests
	// ----------------------------------------
	always_comb begin
		flag_set = 4'h0;
		flag_set[`FLAG_OVERFLOW] = overflow_evt;
		flag_set[`FLAG_CMP_A] = match_a;
		flag_set[`FLAG_CMP_B] = match_b;
		flag_set[`FLAG_CAPTURE] = edge_hit;
		flag_clr = 4'h0;
		if (io_req.wr && io_req.addr == `ADDR_FLAGS)
			flag_clr = io_req.wdata[3:0];
	end

	// Writing one clears; a new event in the same cycle wins
	always_ff @(posedge clock) begin
		if (srst)
			flags <= 4'h0;
		else if (clock_enable)
			flags <= (flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_overflow <= 1'b0;
			irq_compare_a <= 1'b0;
			irq_compare_b <= 1'b0;
			irq_capture <= 1'b0;
		end else if (clock_enable) begin
			irq_overflow <= flags[`FLAG_OVERFLOW] && mask[`FLAG_OVERFLOW] && global_int_enable;
			irq_compare_a <= flags[`FLAG_CMP_A] && mask[`FLAG_CMP_A] && global_int_enable;
			irq_compare_b <= flags[`FLAG_CMP_B] && mask[`FLAG_CMP_B] && global_int_enable;
			irq_capture <= flags[`FLAG_CAPTURE] && mask[`FLAG_CAPTURE] && global_int_enable;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_capture_latch: assert property (clock_enable && edge_hit |=> capture_register == $past(wide_counter) && flags[`FLAG_CAPTURE]) else $error("capture did not latch counter and flag");

	a_capture_readonly: assert property (clock_enable && io_req.wr && (io_req.addr == `ADDR_CAP_LOW || io_req.addr == `ADDR_CAP_HIGH) && !edge_hit |=> $stable(capture_register)) else $error("write changed capture register");

	a_temp_low_read: assert property (clock_enable && io_req.rd && io_req.addr == `ADDR_CAP_LOW |=> temp == $past(capture_register[15:8])) else $error("low read did not load high byte latch");

	a_turn_at_top: assert property (clock_enable && tick && pwm_on && dir == DIR_UP && wide_counter == top && !wr_cnt_low |=> dir == DIR_DOWN && wide_counter == $past(top) - `ONE16) else $error("counter did not turn at TOP");

	a_overflow_zero: assert property (clock_enable && tick && pwm_on && wide_counter == `ZERO16 |=> flags[`FLAG_OVERFLOW]) else $error("overflow flag not set leaving zero");

	a_irq_gate: assert property (clock_enable && flags[`FLAG_OVERFLOW] && mask[`FLAG_OVERFLOW] && global_int_enable |=> irq_overflow) else $error("overflow request not raised");

	a_stop_frozen: assert property (clock_enable && ctrl_b.clk_sel == `CS_STOP && !wr_cnt_low |=> $stable(wide_counter)) else $error("stopped counter moved");

	a_filter_level: assert property (clock_enable && ctrl_b.filter && edge_hit |-> cap_window == {FILTER_DEPTH{ctrl_b.edge_rise}}) else $error("filtered capture without equal samples");

	a_edge_select: assert property (clock_enable && !ctrl_b.filter && edge_hit |-> capture_input_pin == ctrl_b.edge_rise && cap_level != capture_input_pin) else $error("capture on wrong edge");

	c_capture: cover property (clock_enable && edge_hit);
	c_pwm_overflow: cover property (clock_enable && pwm_on && overflow_evt);
	c_pwm_turn: cover property (clock_enable && tick && pwm_on && dir == DIR_UP && wide_counter == top);
endmodule
`default_nettype wire

//--- rtl/timer1_cfg.svh
// Address map, field positions and constants of the 16-bit capture/PWM timer
`ifndef TIMER1_CFG_SVH
`define TIMER1_CFG_SVH

// ----------------------------------------
// I/O register addresses
// ----------------------------------------
`define ADDR_CAP_LOW 6'h26
`define ADDR_CAP_HIGH 6'h27
`define ADDR_CMP_B_LOW 6'h28
`define ADDR_CMP_B_HIGH 6'h29
`define ADDR_CMP_A_LOW 6'h2a
`define ADDR_CMP_A_HIGH 6'h2b
`define ADDR_CNT_LOW 6'h2c
`define ADDR_CNT_HIGH 6'h2d
`define ADDR_CTRL_B 6'h2e
`define ADDR_CTRL_A 6'h2f
`define ADDR_FLAGS 6'h38
`define ADDR_MASK 6'h39

// ----------------------------------------
// Flag and mask bit positions
// ----------------------------------------
`define FLAG_OVERFLOW 0
`define FLAG_CMP_A 1
`define FLAG_CMP_B 2
`define FLAG_CAPTURE 3

// ----------------------------------------
// Counter, prescaler and modes
// ----------------------------------------
`define ZERO16 16'h0000
`define ONE16 16'h0001
`define ALL16 16'hffff
`define TOP_8 16'h00ff
`define TOP_9 16'h01ff
`define TOP_10 16'h03ff
`define CMP_PWM_MASK 16'h03ff
`define WSEL_OFF 2'h0
`define WSEL_8 2'h1
`define WSEL_9 2'h2
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define PRE_MASK_8 10'h007
`define PRE_MASK_64 10'h03f
`define PRE_MASK_256 10'h0ff
`define PRE_MASK_1024 10'h3ff
`define MODE_TOGGLE 2'h1
`define MODE_CLEAR 2'h2
`define MODE_SET 2'h3
`define MODE_INV_BIT 0
`define MODE_ON_BIT 1
`define FILTER_SAMPLES 4

`endif

//--- rtl/timer1_pkg.sv
// Shared types for the 16-bit capture/PWM timer
`default_nettype none
package timer1_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} io_req_t;

	typedef struct packed {
		logic [1:0] mode_a;
		logic [1:0] mode_b;
		logic [1:0] unused;
		logic [1:0] width;
	} ctrl_a_t;

	typedef struct packed {
		logic filter;
		logic edge_rise;
		logic [2:0] unused;
		logic [2:0] clk_sel;
	} ctrl_b_t;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} dir_t;
endpackage
`default_nettype wire

//--- rtl/compare_channel.sv
// One compare unit: buffered compare value, match detection, pin action
`default_nettype none
`include "timer1_cfg.svh"

module compare_channel
	import timer1_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic clock_enable,
	// Register side
	input wire logic write_en,
	input wire logic [15:0] write_value,
	output logic [15:0] read_value,
	// Counter side
	input wire logic pwm_on,
	input wire logic undivided,
	input wire logic step,
	input wire logic rising,
	input wire logic [15:0] count_next,
	input wire logic [15:0] top,
	input wire logic [1:0] mode,
	// Results
	output logic match,
	output logic pin
);
	logic [15:0] hold;
	logic [15:0] active;
	logic alt;
	logic [15:0] cmp;
	logic hit;

	assign cmp = pwm_on ? (active & `CMP_PWM_MASK) : active;
	assign hit = step && (count_next == cmp);
	assign read_value = hold;

	// Hold takes every write; PWM defers it to TOP so no odd pulse appears
	always_ff @(posedge clock) begin
		if (srst) begin
			hold <= `ZERO16;
			active <= `ZERO16;
		end else if (clock_enable) begin
			if (write_en)
				hold <= write_value;
			if (write_en && !pwm_on)
				active <= write_value;
			else if (pwm_on && step && count_next == top)
				active <= hold;
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			match <= 1'b0;
		else if (clock_enable)
			match <= hit;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pin <= 1'b0;
			alt <= 1'b0;
		end else if (clock_enable && hit) begin
			if (!pwm_on) begin
				case (mode)
				`MODE_TOGGLE: pin <= !pin;
				`MODE_CLEAR: pin <= 1'b0;
				`MODE_SET: pin <= 1'b1;
				default: pin <= pin;
				endcase
			end else if (mode[`MODE_ON_BIT]) begin
				if (cmp == `ZERO16)
					pin <= mode[`MODE_INV_BIT];
				else if (cmp == top && undivided)
					pin <= !mode[`MODE_INV_BIT];
				else if (cmp == top) begin
					alt <= !alt;
					pin <= alt ? mode[`MODE_INV_BIT] : !mode[`MODE_INV_BIT];
				end else
					pin <= rising ? mode[`MODE_INV_BIT] : !mode[`MODE_INV_BIT];
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_hold_readback: assert property (clock_enable && write_en |=> read_value == $past(write_value)) else $error("compare readback is not the last write");

	a_top_transfer: assert property (clock_enable && pwm_on && step && count_next == top |=> active == $past(hold)) else $error("compare not transferred at TOP");

	a_clear_rising: assert property (clock_enable && pwm_on && hit && mode == `MODE_CLEAR && rising && cmp != `ZERO16 && cmp != top |=> !pin) else $error("non-inverted output not cleared on up match");
endmodule
`default_nettype wire

//--- testbench/cpu_model.sv
// CPU core model driving the timer's I/O register port
`default_nettype none
module cpu_model
	import timer1_pkg::*;
(
	// Clock
	input wire logic clock,
	// I/O register port
	output var io_req_t io_req,
	input wire logic [7:0] io_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial io_req = '0;

	// ----------------------------------------
	// Single-byte accesses
	// ----------------------------------------
	// One access in flight at a time, so the shared latch is never interleaved
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clock);
		#1 io_req = '0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clock);
		#1 io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clock);
		#1 io_req = '0;
		d = io_rdata;
	endtask

	// ----------------------------------------
	// 16-bit accesses through the shared latch
	// ----------------------------------------
	// Low byte first, so the latch holds the matching high byte
	task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
		logic [7:0] l;
		logic [7:0] h;
		rd(lo, l);
		rd(lo + 6'h01, h);
		v = {h, l};
	endtask

	// High byte first; the low write commits both halves
	task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
		wr(lo + 6'h01, v[15:8]);
		wr(lo, v[7:0]);
	endtask
endmodule
`default_nettype wire

//--- testbench/timer1_capture_and_phase_correct_pwm_tb.sv
// Self-checking bench for the capture register and phase-correct PWM
`default_nettype none
module timer1_capture_and_phase_correct_pwm_tb;
	import timer1_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0;
	logic srst = 1'b1;
	logic cap_pin = 1'b0;
	logic gie = 1'b0;
	io_req_t io_req;
	logic [7:0] io_rdata;
	logic pwm_out_a;
	logic pwm_oe_a;
	logic pwm_out_b;
	logic pwm_oe_b;
	logic irq_ovf;
	logic irq_cmp_a;
	logic irq_cmp_b;
	logic irq_cap;
	logic ext_pin = 1'b0;
	logic ce = 1'b1;
	int high_cycles;
	int failures = 0;
	int check_count = 0;
	logic [15:0] v;
	logic [7:0] b;

	always #10 clock = ~clock;

	timer1_capture_pwm dut (
		.clock(clock), .srst(srst), .clock_enable(ce),
		.io_req(io_req), .io_rdata(io_rdata),
		.capture_input_pin(cap_pin), .ext_clock_pin(ext_pin),
		.pwm_out_a(pwm_out_a), .pwm_oe_a(pwm_oe_a),
		.pwm_out_b(pwm_out_b), .pwm_oe_b(pwm_oe_b),
		.global_int_enable(gie), .irq_overflow(irq_ovf),
		.irq_compare_a(irq_cmp_a), .irq_compare_b(irq_cmp_b), .irq_capture(irq_cap)
	);

	cpu_model cpu (.clock(clock), .io_req(io_req), .io_rdata(io_rdata));

	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// ----------------------------------------
	// PWM run: both channels, duty measured over one period
	// ----------------------------------------
	// Channel A non-inverted, B inverted, same compare value
	task automatic pwm_run(input int w, input int cmp);
		int top;
		int period;
		int ha;
		int hb;
		int ea;
		logic [15:0] wv;
		top = (256 << (w - 1)) - 1;
		period = 2 * top;
		ha = 0;
		hb = 0;
		// Upper six bits set to show they play no part in matching
		wv = 16'(cmp) | 16'hfc00;
		cpu.wr(6'h2f, 8'hb0 | 8'(w));
		// Start from zero so TOP, and with it the compare transfer, comes soon
		cpu.wr16(6'h2c, 16'h0000);
		cpu.wr16(6'h2a, wv);
		cpu.wr16(6'h28, wv);
		cpu.rd(6'h2a, b);
		check("cmp_a_readback", {8'h00, b}, {8'h00, wv[7:0]});
		settle(2 * period + 4);
		repeat (period) begin
			@(posedge clock);
			#2;
			if (pwm_out_a === 1'b1)
				ha++;
			if (pwm_out_b === 1'b1)
				hb++;
		end
		ea = (cmp == 0) ? 0 : (cmp == top) ? period : 2 * cmp;
		check("pwm_a_high", 16'(ha), 16'(ea));
		check("pwm_b_high", 16'(hb), 16'(period - ea));
		check("pwm_oe_a", {15'h0, pwm_oe_a}, 16'h0001);
		check("pwm_oe_b", {15'h0, pwm_oe_b}, 16'h0001);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		settle(6);
		srst = 1'b0;
		cpu.rd16(6'h26, v);
		check("cap_reset", v, 16'h0000);
		cpu.wr16(6'h26, 16'h55aa);
		cpu.rd16(6'h26, v);
		check("cap_write_ignored", v, 16'h0000);
		cpu.rd(6'h30, b);
		check("unmapped", {8'h00, b}, 16'h0000);
		// Counter stopped so the captured value is known
		cpu.wr(6'h2e, 8'h40);
		cpu.wr16(6'h2c, 16'h1234);
		cpu.wr(6'h38, 8'h0f);
		cap_pin = 1'b1;
		settle(4);
		cpu.rd16(6'h26, v);
		check("cap_rising", v, 16'h1234);
		cpu.rd(6'h38, b);
		check("cap_flag", {8'h00, b & 8'h08}, 16'h0008);
		cpu.wr(6'h2e, 8'h00);
		cpu.wr16(6'h2c, 16'h0456);
		cap_pin = 1'b0;
		settle(4);
		cpu.rd16(6'h26, v);
		check("cap_falling", v, 16'h0456);
		cpu.wr16(6'h2c, 16'h0789);
		cap_pin = 1'b1;
		settle(4);
		cpu.rd16(6'h26, v);
		check("cap_wrong_edge", v, 16'h0456);
		cpu.wr(6'h2e, 8'hc0);
		cap_pin = 1'b0;
		settle(8);
		cpu.wr16(6'h2c, 16'h0abc);
		cap_pin = 1'b1;
		settle(2);
		cap_pin = 1'b0;
		settle(8);
		cpu.rd16(6'h26, v);
		check("cap_filter_short", v, 16'h0456);
		cap_pin = 1'b1;
		settle(8);
		cpu.rd16(6'h26, v);
		check("cap_filter_long", v, 16'h0abc);
		// External rising edges count; a frozen block ignores them
		cpu.wr(6'h2e, 8'h07);
		cpu.wr16(6'h2c, 16'h0000);
		repeat (3) begin
			ext_pin = 1'b1;
			settle(2);
			ext_pin = 1'b0;
			settle(2);
		end
		ce = 1'b0;
		ext_pin = 1'b1;
		settle(2);
		ext_pin = 1'b0;
		settle(2);
		ce = 1'b1;
		cpu.rd16(6'h2c, v);
		check("ext_count", v, 16'h0003);
		cpu.wr(6'h2e, 8'h01);
		for (int w = 1; w <= 3; w++) begin
			pwm_run(w, 'h40);
			pwm_run(w, 0);
			pwm_run(w, (256 << (w - 1)) - 1);
		end
		// Divided tick with compare at TOP: whole periods alternate high and low
		cpu.wr(6'h2e, 8'h02);
		cpu.wr(6'h2f, 8'hb1);
		cpu.wr16(6'h2c, 16'h0000);
		cpu.wr16(6'h2a, 16'h00ff);
		cpu.wr16(6'h28, 16'h0040);
		settle(16'h2000);
		high_cycles = 0;
		repeat (16'h1fe0) begin
			@(posedge clock);
			#2;
			if (pwm_out_a === 1'b1)
				high_cycles++;
		end
		check("pwm_a_top_divided", 16'(high_cycles), 16'h0ff0);
		cpu.wr(6'h2e, 8'h01);
		cpu.wr(6'h38, 8'h0f);
		settle(2100);
		cpu.rd(6'h38, b);
		check("ovf_flag", {8'h00, b & 8'h01}, 16'h0001);
		cpu.wr(6'h39, 8'h0f);
		gie = 1'b1;
		settle(3);
		check("irq_ovf_on", {15'h0, irq_ovf}, 16'h0001);
		check("irq_cmp_a_on", {15'h0, irq_cmp_a}, 16'h0001);
		check("irq_cmp_b_on", {15'h0, irq_cmp_b}, 16'h0001);
		check("irq_cap_idle", {15'h0, irq_cap}, 16'h0000);
		cap_pin = 1'b0;
		settle(3);
		check("irq_cap_on", {15'h0, irq_cap}, 16'h0001);
		gie = 1'b0;
		settle(3);
		check("irq_ovf_off", {15'h0, irq_ovf}, 16'h0000);
		cpu.wr(6'h2f, 8'h03);
		settle(3);
		check("pwm_oe_off", {15'h0, pwm_oe_a}, 16'h0000);
		check("pwm_oe_b_off", {15'h0, pwm_oe_b}, 16'h0000);
		summarize();
	end

	// Run needs about 51k cycles; cut off well beyond that
	initial begin
		#1800000;
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
